// ---- ums_pkg.sv ----
// Purpose: shared constants for the modem status and reset block
// Assumes: 25 MHz clock, AHB-Lite register access, 32-bit words
// Notes: register offsets are byte addresses (index times four)
package ums_pkg;
  // register indices as printed, byte address is four times index
  localparam logic [2:0] IDX_INT_ENABLE = 3'h1;
  localparam logic [2:0] IDX_INT_IDENT = 3'h2;
  localparam logic [2:0] IDX_LINE_CTRL = 3'h3;
  localparam logic [2:0] IDX_MODEM_CTRL = 3'h4;
  localparam logic [2:0] IDX_LINE_STATUS = 3'h5;
  localparam logic [2:0] IDX_MODEM_STATUS = 3'h6;
  localparam logic [2:0] IDX_BAUD = 3'h7;
  // fifo control shares index 2 on write
  localparam logic [2:0] IDX_FIFO_CTRL = 3'h2;
  // reset values
  localparam logic [7:0] INT_IDENT_RESET = 8'h01;
  localparam logic [7:0] LINE_STATUS_RESET = 8'h60;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [15:0] BAUD_RESET = 16'h0001;
  // modem control bit positions
  localparam int MCTL_TERM_READY = 32'h0000_0000;
  localparam int MCTL_REQ_SEND = 32'h0000_0001;
  localparam int MCTL_AUX_ONE = 32'h0000_0002;
  localparam int MCTL_AUX_TWO = 32'h0000_0003;
  localparam int MCTL_LOOP = 32'h0000_0004;
  // minimum reset hold time of 500 ns, for the system outside
  localparam int RESET_HOLD_NS = 32'h0000_01F4;
  localparam int CLK_PERIOD_NS = 32'h0000_0028;
  localparam int RESET_HOLD_CYC = (RESET_HOLD_NS + CLK_PERIOD_NS - 32'h0000_0001) / CLK_PERIOD_NS;
  // AHB transfer type
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

// ---- ums_baud_if.sv ----
// Purpose: carries baud counter control between divider and top
// Assumes: one clock domain
// Notes: divisor comes from software, tick is one-cycle enable
`timescale 1ns/100ps
interface ums_baud_if;
  logic [15:0] divisor;
  logic tick;
  modport ctrl (output divisor, input tick);
  modport div (input divisor, output tick);
endinterface // ums_baud_if

// ---- ums_baud_div.sv ----
// Purpose: baud-rate enable divider for the channel
// Assumes: divisor of zero behaves as one
// Notes: counter restarts on reset
`timescale 1ns/100ps
module ums_baud_div
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // divisor and tick
  ums_baud_if.div baud
);
  logic [15:0] count;
  wire logic atEnd = (count <= 16'h0001);

  // down counter, reloads on each tick
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      count <= ums_pkg::BAUD_RESET;
    else if (atEnd)
      count <= baud.divisor;
    else
      count <= count - 16'h0001;
  end

  assign baud.tick = atEnd && !sys_rst;
endmodule // ums_baud_div

// ---- ums_modem_status.sv ----
// Purpose: modem status register, reset defaults and AHB-Lite slave
// Assumes: modem inputs are active low and synchronous to clk
// Notes: change flags clear on status read, a new change wins
//
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/100ps
module ums_modem_status
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // modem inputs, active low
  input wire logic carrier_detect_in_n,
  input wire logic phone_call_alert_in_n,
  input wire logic modem_ready_in_n,
  input wire logic clear_to_send_in_n,
  // modem and serial outputs
  output logic terminal_ready_out_n,
  output logic request_send_out_n,
  output logic serial_tx_out_0,
  output logic serial_tx_out_1,
  // interrupt pin, tristate as two signals
  output logic irqOut,
  output logic irqOe,
  // baud enable for the serial engines
  output logic baudTick
);
  // control and status registers
  logic [7:0] interrupt_enable_reg;
  logic [7:0] fifo_control_reg;
  logic [7:0] line_control_reg;
  logic [7:0] modem_line_control_reg;
  logic [7:0] interrupt_ident_reg;
  logic [7:0] line_status_reg;
  logic [3:0] changeFlags;
  logic [3:0] prevLevel;
  logic [15:0] baudDivisor;
  // data-phase capture
  logic dpWrite;
  logic dpRead;
  logic [2:0] dpIdx;

  // index match, shared by the write strobes and the status read
  function automatic logic hitIdx(input logic [2:0] idx, input logic [2:0] want);
  begin
    hitIdx = (idx == want);
  end
  endfunction

  // address phase decode
  wire logic addrValid = hsel && hready && (htrans == ums_pkg::HTRANS_NONSEQ);
  wire logic [2:0] addrIdx = haddr[4:2];

  // live levels, active high
  wire logic [3:0] lineLevel = ~{carrier_detect_in_n, phone_call_alert_in_n,
                                 modem_ready_in_n, clear_to_send_in_n};
  wire logic loopMode = modem_line_control_reg[ums_pkg::MCTL_LOOP];
  wire logic [7:0] ctlBits = modem_line_control_reg;
  // loop sources in bit order 7..4
  wire logic [3:0] loopLevel = {ctlBits[ums_pkg::MCTL_AUX_TWO], ctlBits[ums_pkg::MCTL_AUX_ONE],
                                ctlBits[ums_pkg::MCTL_TERM_READY],
                                ctlBits[ums_pkg::MCTL_REQ_SEND]};
  // upper nibble is combinational so it follows inputs even in reset
  wire logic [3:0] statusHigh = loopMode ? loopLevel : lineLevel;
  wire logic [7:0] modem_line_status_reg = {statusHigh, changeFlags};

  // change detection on the reported level
  wire logic [3:0] edgeSeen;
  assign edgeSeen[3] = statusHigh[3] ^ prevLevel[3];
  assign edgeSeen[2] = prevLevel[2] & ~statusHigh[2];
  assign edgeSeen[1] = statusHigh[1] ^ prevLevel[1];
  assign edgeSeen[0] = statusHigh[0] ^ prevLevel[0];
  wire logic statusRead = dpRead && hitIdx(dpIdx, ums_pkg::IDX_MODEM_STATUS);
  // a change in the clearing cycle survives the read
  wire logic [3:0] next_changeFlags = (statusRead ? 4'h0 : changeFlags) | edgeSeen;

  // write strobes, taken in the data phase
  wire logic wrIntEnable = dpWrite && hitIdx(dpIdx, ums_pkg::IDX_INT_ENABLE);
  wire logic wrFifoCtrl = dpWrite && hitIdx(dpIdx, ums_pkg::IDX_FIFO_CTRL);
  wire logic wrLineCtrl = dpWrite && hitIdx(dpIdx, ums_pkg::IDX_LINE_CTRL);
  wire logic wrModemCtrl = dpWrite && hitIdx(dpIdx, ums_pkg::IDX_MODEM_CTRL);
  wire logic wrBaud = dpWrite && hitIdx(dpIdx, ums_pkg::IDX_BAUD);

  // read mux, unmapped indices read zero
  logic [7:0] next_rdByte;
  always_comb
  begin
    next_rdByte = 8'h00;
    unique case (addrIdx)
      ums_pkg::IDX_INT_ENABLE: next_rdByte = interrupt_enable_reg;
      ums_pkg::IDX_INT_IDENT: next_rdByte = interrupt_ident_reg;
      ums_pkg::IDX_LINE_CTRL: next_rdByte = line_control_reg;
      ums_pkg::IDX_MODEM_CTRL: next_rdByte = modem_line_control_reg;
      ums_pkg::IDX_LINE_STATUS: next_rdByte = line_status_reg;
      // flags due at this edge, else a change here is cleared unreported
      ums_pkg::IDX_MODEM_STATUS: next_rdByte = {statusHigh, next_changeFlags};
      ums_pkg::IDX_BAUD: next_rdByte = baudDivisor[7:0];
      default: next_rdByte = 8'h00;
    endcase
  end

  // bus phase tracking and read data register
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      dpWrite <= 1'b0;
      dpRead <= 1'b0;
      dpIdx <= 3'h0;
      hrdata <= 32'h0000_0000;
    end
    else
    begin
      dpWrite <= addrValid && hwrite;
      dpRead <= addrValid && !hwrite;
      dpIdx <= addrIdx;
      if (addrValid && !hwrite)
        hrdata <= {24'h00_0000, next_rdByte};
    end
  end

  // control registers return to zero on reset, the baud divisor to one
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      interrupt_enable_reg <= ums_pkg::CTRL_RESET;
      fifo_control_reg <= ums_pkg::CTRL_RESET;
      line_control_reg <= ums_pkg::CTRL_RESET;
      modem_line_control_reg <= ums_pkg::CTRL_RESET;
      baudDivisor <= ums_pkg::BAUD_RESET;
    end
    else
    begin
      if (wrIntEnable)
        interrupt_enable_reg <= {4'h0, hwdata[3:0]};
      if (wrFifoCtrl)
        fifo_control_reg <= hwdata[7:0];
      if (wrLineCtrl)
        line_control_reg <= hwdata[7:0];
      if (wrModemCtrl)
        modem_line_control_reg <= {3'h0, hwdata[4:0]};
      if (wrBaud)
        baudDivisor <= {8'h00, hwdata[7:0]};
    end
  end

  // status defaults; transmitter engine lies outside, so these hold
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      interrupt_ident_reg <= ums_pkg::INT_IDENT_RESET;
      line_status_reg <= ums_pkg::LINE_STATUS_RESET;
      changeFlags <= 4'h0;
      // history follows the lines in reset, so a line held through it flags nothing
      prevLevel <= statusHigh;
    end
    else
    begin
      changeFlags <= next_changeFlags;
      prevLevel <= statusHigh;
    end
  end

  // marks edges past the first one after reset, for the change-flag and pin checks
  logic primed;
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      primed <= 1'b0;
    else
      primed <= 1'b1;
  end

  // modem and serial pins; irq tristated since no interrupt logic here
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      terminal_ready_out_n <= 1'b1;
      request_send_out_n <= 1'b1;
      serial_tx_out_0 <= 1'b1;
      serial_tx_out_1 <= 1'b1;
      irqOut <= 1'b0;
      irqOe <= 1'b0;
    end
    else
    begin
      // loop mode keeps the pins inactive
      terminal_ready_out_n <= loopMode | ~ctlBits[ums_pkg::MCTL_TERM_READY];
      request_send_out_n <= loopMode | ~ctlBits[ums_pkg::MCTL_REQ_SEND];
      serial_tx_out_0 <= 1'b1;
      serial_tx_out_1 <= 1'b1;
      irqOut <= 1'b0;
      irqOe <= 1'b0;
    end
  end

  // baud divider restarts with reset
  ums_baud_if baudLink ();
  assign baudLink.divisor = baudDivisor;
  assign baudTick = baudLink.tick;
  ums_baud_div u_baud
  (
    .clk(clk),
    .sys_rst(sys_rst),
    .baud(baudLink)
  );

  // zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // carrier detect flag follows a level change within one cycle
  a_carrier_change: assert property (@(posedge clk) disable iff (sys_rst)
    primed && (statusHigh[3] != $past(statusHigh[3]))
    |=> changeFlags[3])
    else $error("carrier change not flagged");

  // ring flag only on trailing edge
  a_ring_edge: assert property (@(posedge clk) disable iff (sys_rst)
    primed && !$past(changeFlags[2]) && !$past(statusRead) && $rose(changeFlags[2])
    |-> ($past(prevLevel[2]) && !$past(statusHigh[2])))
    else $error("ring flag set without trailing edge");

  // modem-ready flag on change
  a_ready_change: assert property (@(posedge clk) disable iff (sys_rst)
    primed && $changed(statusHigh[1]) |=> changeFlags[1])
    else $error("modem ready change not flagged");

  // clear-to-send flag on change
  a_clear_change: assert property (@(posedge clk) disable iff (sys_rst)
    primed && $changed(statusHigh[0]) |=> changeFlags[0])
    else $error("clear to send change not flagged");

  // read with no new change clears flags
  a_read_clear: assert property (@(posedge clk) disable iff (sys_rst)
    statusRead && (edgeSeen == 4'h0) |=> changeFlags == 4'h0)
    else $error("status read did not clear flags");

  // loop mode mirrors the control bits
  a_loop_mirror: assert property (@(posedge clk) disable iff (sys_rst)
    loopMode |-> modem_line_status_reg[7:4] == {ctlBits[3], ctlBits[2], ctlBits[0], ctlBits[1]})
    else $error("loop mirror wrong");

  // normal mode shows inverted inputs
  a_line_invert: assert property (@(posedge clk) disable iff (sys_rst)
    !loopMode |-> modem_line_status_reg[7:4] == ~{carrier_detect_in_n,
      phone_call_alert_in_n, modem_ready_in_n, clear_to_send_in_n})
    else $error("status does not follow inputs");

  // reset values one edge after reset
  a_reset_vals: assert property (@(posedge clk)
    $past(sys_rst) |-> (interrupt_ident_reg == 8'h01) && (line_status_reg == 8'h60)
      && (changeFlags == 4'h0) && (modem_line_control_reg == 8'h00))
    else $error("reset values wrong");

  // terminal-ready pin inverts control bit 0 outside loop
  a_term_pin: assert property (@(posedge clk) disable iff (sys_rst)
    primed && !$past(loopMode) |-> terminal_ready_out_n == !$past(ctlBits[0]))
    else $error("terminal ready pin wrong");

  // pins idle high and irq output enable low one edge after reset
  a_reset_pins: assert property (@(posedge clk)
    $past(sys_rst) |-> serial_tx_out_0 && serial_tx_out_1 && request_send_out_n
      && terminal_ready_out_n && !irqOe)
    else $error("pins not idle after reset");

  // a flag is only cleared once the read has carried it out
  a_read_report: assert property (@(posedge clk) disable iff (sys_rst)
    statusRead |-> (changeFlags & ~hrdata[3:0]) == 4'h0)
    else $error("change flag cleared unreported");

  // a read with no trailing ring edge leaves the ring flag low
  a_ring_quiet: assert property (@(posedge clk) disable iff (sys_rst)
    statusRead && !(prevLevel[2] && !statusHigh[2]) |=> !changeFlags[2])
    else $error("ring flag survived read");

  // the control bits the pins follow land whole in the data phase
  a_ctrl_write: assert property (@(posedge clk) disable iff (sys_rst)
    wrModemCtrl |=> modem_line_control_reg == {3'h0, $past(hwdata[4:0])})
    else $error("control write lost");
endmodule // ums_modem_status

// ---- ums_modem_model.sv ----
// Purpose: modem side of the handshake lines for the status block bench
// Assumes: lines are active low and change just after a clock edge
// Notes: a real modem drives all four lines at all times, so no float
`timescale 1ns/100ps
module ums_modem_model
(
  // clock
  input wire logic clk,
  // wanted levels: carrier, ring, modem ready, clear to send
  input wire logic [3:0] lineCmd,
  // handshake lines, active low
  output logic carrier_detect_in_n,
  output logic phone_call_alert_in_n,
  output logic modem_ready_in_n,
  output logic clear_to_send_in_n
);
  // lines move one edge after the request, like a registered driver
  initial
  begin
    {carrier_detect_in_n, phone_call_alert_in_n, modem_ready_in_n, clear_to_send_in_n} = 4'hF;
  end
  always @(posedge clk)
  begin
    carrier_detect_in_n <= lineCmd[3];
    phone_call_alert_in_n <= lineCmd[2];
    modem_ready_in_n <= lineCmd[1];
    clear_to_send_in_n <= lineCmd[0];
  end
endmodule // ums_modem_model

// ---- test_uart_modem_status_and_reset.sv ----
// Purpose: self-checking bench for the modem status and reset block
// Assumes: zero wait state slave, reads taken at the data phase edge
// Notes: lines idle high, so the status byte starts at zero
`timescale 1ns/100ps
`define CHK(g, e) begin numChecks++; if ((g) !== (e)) begin errorCnt++; \
  $display("BAD %0t got %0h exp %0h", $time, (g), (e)); end end
module test_uart_modem_status_and_reset;
  logic clk = 1'b0, sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [3:0] lineCmd = 4'hF;
  logic hreadyout, hresp, cdN, ringN, readyN, ctsN, dtrN, rtsN, tx0, tx1, irqOut, irqOe, baudTick;
  int errorCnt = 0, numChecks = 0, cyc = 0;
  ums_modem_model modem (.clk(clk), .lineCmd(lineCmd), .carrier_detect_in_n(cdN),
    .phone_call_alert_in_n(ringN), .modem_ready_in_n(readyN), .clear_to_send_in_n(ctsN));
  ums_modem_status DUT (.clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .carrier_detect_in_n(cdN),
    .phone_call_alert_in_n(ringN), .modem_ready_in_n(readyN), .clear_to_send_in_n(ctsN),
    .terminal_ready_out_n(dtrN), .request_send_out_n(rtsN), .serial_tx_out_0(tx0),
    .serial_tx_out_1(tx1), .irqOut(irqOut), .irqOe(irqOe), .baudTick(baudTick));
  // clock, 40 ns period
  initial
  begin
    forever #20 clk = ~clk;
  end
  // one single word transfer, entered just after an edge
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] wd,
    output logic [31:0] rd);
    haddr <= a;
    hwrite <= w;
    hsel <= 1'b1;
    htrans <= ums_pkg::HTRANS_NONSEQ;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask
  // counts baud enables over a window, sampled mid-cycle where the tick is settled
  task automatic countTicks(input int len, output int n);
    n = 0;
    repeat (len)
    begin
      @(negedge clk);
      if (baudTick === 1'b1) n++;
    end
  endtask
  // register and pin values straight after reset
  task automatic checkReset;
    logic [31:0] rd;
    int n;
    bus(32'h08, 1'b0, 32'h0, rd); `CHK(rd, 32'h01)
    bus(32'h14, 1'b0, 32'h0, rd); `CHK(rd, 32'h60)
    bus(32'h18, 1'b0, 32'h0, rd); `CHK(rd, 32'h00)
    bus(32'h04, 1'b0, 32'h0, rd); `CHK(rd, 32'h00)
    bus(32'h0C, 1'b0, 32'h0, rd); `CHK(rd, 32'h00)
    bus(32'h10, 1'b0, 32'h0, rd); `CHK(rd, 32'h00)
    bus(32'h00, 1'b0, 32'h0, rd); `CHK(rd, 32'h00)
    `CHK({dtrN, rtsN, tx0, tx1, irqOe, irqOut}, 6'h3C)
    `CHK(hresp, 1'b0)
    countTicks(4, n); `CHK(n, 4)
  endtask
  // inputs asserted, then released; reads clear the change flags
  task automatic checkLevels;
    logic [31:0] rd;
    lineCmd <= 4'h0;
    repeat (3) @(posedge clk);
    bus(32'h18, 1'b0, 32'h0, rd); `CHK(rd[7:0], 8'hFB)
    bus(32'h18, 1'b0, 32'h0, rd); `CHK(rd[7:0], 8'hF0)
    lineCmd <= 4'hF;
    repeat (3) @(posedge clk);
    bus(32'h18, 1'b0, 32'h0, rd); `CHK(rd[7:0], 8'h0F)
    bus(32'h18, 1'b0, 32'h0, rd); `CHK(rd[7:0], 8'h00)
  endtask
  // loop mode routes each control bit to its status bit
  task automatic checkLoop;
    logic [31:0] rd;
    logic [3:0] exp [4];
    exp = '{4'h2, 4'h1, 4'h4, 4'h8};
    for (int i = 0; i < 4; i++)
    begin
      bus(32'h10, 1'b1, 32'h10 | (32'h1 << i), rd);
      bus(32'h18, 1'b0, 32'h0, rd);
      `CHK(rd[7:4], exp[i])
      `CHK({dtrN, rtsN}, 2'h3)
    end
    bus(32'h10, 1'b1, 32'h03, rd);
    repeat (2) @(posedge clk);
    `CHK({dtrN, rtsN}, 2'h0)
    bus(32'h10, 1'b1, 32'h00, rd);
    repeat (2) @(posedge clk);
    `CHK(dtrN, 1'b1)
  endtask
  // a slower divisor thins out the baud enables
  task automatic checkBaud;
    logic [31:0] rd;
    int n;
    bus(32'h1C, 1'b1, 32'h04, rd);
    repeat (8) @(posedge clk);
    countTicks(8, n); `CHK(n, 2)
  endtask
  // mid-run reset drops flags and control, the lines still show through
  task automatic checkRerun;
    logic [31:0] rd;
    int n;
    bus(32'h10, 1'b1, 32'h03, rd);
    lineCmd <= 4'h7;
    repeat (3) @(posedge clk);
    `CHK({dtrN, rtsN}, 2'h0)
    sys_rst <= 1'b1;
    repeat (ums_pkg::RESET_HOLD_CYC) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    bus(32'h18, 1'b0, 32'h0, rd); `CHK(rd, 32'h80)
    bus(32'h10, 1'b0, 32'h0, rd); `CHK(rd, 32'h00)
    `CHK({dtrN, rtsN}, 2'h3)
    countTicks(4, n); `CHK(n, 4)
  endtask
  task automatic printVerdict;
    if (errorCnt == 0 && numChecks > 0)
    begin
      $display("No errors found");
    end
    else
    begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // hang guard, far above the hundred or so cycles the run needs
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      errorCnt++;
      $display("BAD %0t timeout", $time);
      printVerdict();
    end
  end
  // reset held the full minimum time, longer than the usual four cycles
  initial
  begin
    repeat (ums_pkg::RESET_HOLD_CYC) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    checkReset();
    checkLevels();
    checkLoop();
    checkBaud();
    checkRerun();
    printVerdict();
  end
endmodule // test_uart_modem_status_and_reset
